// >>> bcr_pkg.sv
// Package: opcode fields, phase codes and widths for the branch/call/return decoder
package bcr_pkg;
    localparam int PC_W     = 13;
    localparam int INSN_W   = 14;
    localparam int FADDR_W  = 7;
    localparam int STK_D    = 8;
    localparam int STK_PW   = 3;
    // Opcode patterns (bits 13:11, 13:10 or 13:8, or full word)
    localparam logic [3:0]  OP_BTSS   = 4'h7;   // 01 11bb
    localparam logic [2:0]  OP_CALL   = 3'h4;   // 10 0kkk
    localparam logic [2:0]  OP_JUMP   = 3'h5;   // 10 1kkk
    localparam logic [5:0]  OP_INC    = 6'h0A;  // 00 1010
    localparam logic [3:0]  OP_RETURN_WITH_LITERAL  = 4'hD;   // 11 01xx
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam int BIT_HI   = 9;
    localparam int BIT_LO   = 7;
    localparam int DEST_POS = 7;
    localparam int LIT_HI   = 10;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    // Four phases of an instruction cycle
    typedef enum logic [1:0] {
        BCR_Q1 = 2'b00,
        BCR_Q2 = 2'b01,
        BCR_Q3 = 2'b10,
        BCR_Q4 = 2'b11
    } bcr_phase_e;
endpackage

// >>> bcr_decoder.sv
// Decode and execution control for bit-skip, call, jump, increment and returns
// Contract
// - A bit-test-skip whose tested bit is one turns the next instruction into a no-op.
// - A bit-test-skip whose tested bit is zero lets the next instruction run, one cycle.
// - A call pushes the next instruction's address before redirecting the counter.
// - A call loads pc 10:0 from its literal and 12:11 from latch bits 4:3, then a no-op.
// - A jump loads pc 10:0 from its literal and 12:11 from latch bits 4:3, then a no-op.
// - Increment adds one to the file register, writes W or the file, sets only zero.
// - Return-with-literal loads W with the literal and pops the stack into the counter.
// - Return pops the stack into the counter in the last phase, two cycles, no flags.
`timescale 1ns/1ps
module bcr_decoder #(
    parameter int STK_D = bcr_pkg::STK_D
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic [bcr_pkg::INSN_W-1:0]  insn_data,
    input  wire logic [7:0]                  file_rdata,
    input  wire logic [7:0]                  upper_pc_latch,
    output logic [bcr_pkg::PC_W-1:0]         pc_out,
    output logic [bcr_pkg::FADDR_W-1:0]      file_addr,
    output logic [7:0]                       file_wdata,
    output logic                             file_we,
    output logic [7:0]                       w_out,
    output logic                             zero_flag,
    output logic                             zero_we,
    output logic [1:0]                       phase_out,
    output logic                             flush_out,
    output logic                             stack_top_valid,
    output logic [bcr_pkg::PC_W-1:0]         stack_top
);
    bcr_pkg::bcr_phase_e phase_reg;
    logic [bcr_pkg::INSN_W-1:0] ir_reg;
    logic [bcr_pkg::PC_W-1:0]   pc_reg;
    logic                       flush_reg;
    logic [7:0]                 w_reg;
    logic [7:0]                 sum_reg;
    logic                       bit_one_reg;
    logic [bcr_pkg::PC_W-1:0]   stk_reg [STK_D];
    logic [bcr_pkg::STK_PW-1:0] sp_reg;
    logic [3:0]                 depth_reg;

    // Decoded classes; a flushed cycle executes as a no-op
    logic is_btss, is_call, is_jump, is_inc, is_return_with_literal, is_ret, live;
    logic [bcr_pkg::PC_W-1:0] target;
    logic [bcr_pkg::PC_W-1:0] pop_val;
    assign live     = !flush_reg;
    assign is_btss  = live && ir_reg[13:10] == bcr_pkg::OP_BTSS;
    assign is_call  = live && ir_reg[13:11] == bcr_pkg::OP_CALL;
    assign is_jump  = live && ir_reg[13:11] == bcr_pkg::OP_JUMP;
    assign is_inc   = live && ir_reg[13:8]  == bcr_pkg::OP_INC;
    assign is_return_with_literal = live && ir_reg[13:10] == bcr_pkg::OP_RETURN_WITH_LITERAL;
    assign is_ret   = live && ir_reg == bcr_pkg::OP_RETURN;
    // Upper bits come from the latch so pages above 2K are reachable
    assign target   = {upper_pc_latch[bcr_pkg::LATCH_HI:bcr_pkg::LATCH_LO],
                       ir_reg[bcr_pkg::LIT_HI:0]};
    assign pop_val  = stk_reg[sp_reg - 3'h1];

    // Phase counter: Q1..Q4 make one instruction cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_reg <= bcr_pkg::BCR_Q1;
        end else begin
            phase_reg <= bcr_pkg::bcr_phase_e'(phase_reg + 2'h1);
        end
    end

    // Q4 latches the fetched word; pc points at the next word (prefetch)
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ir_reg <= 14'h0000;
        end else if (phase_reg == bcr_pkg::BCR_Q4) begin
            ir_reg <= insn_data;
        end
    end

    // Q2 reads the file operand and forms the increment
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sum_reg     <= 8'h00;
            bit_one_reg <= 1'b0;
        end else if (phase_reg == bcr_pkg::BCR_Q2) begin
            sum_reg     <= file_rdata + 8'h01;
            bit_one_reg <= file_rdata[ir_reg[bcr_pkg::BIT_HI:bcr_pkg::BIT_LO]];
        end
    end

    // Program counter and flush: a flush voids the word already prefetched
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_reg    <= bcr_pkg::PC_RST;
            flush_reg <= 1'b0;
        end else if (phase_reg == bcr_pkg::BCR_Q4) begin
            flush_reg <= 1'b0;
            if (is_call || is_jump) begin
                pc_reg    <= target;
                flush_reg <= 1'b1;
            end else if (is_return_with_literal || is_ret) begin
                pc_reg    <= pop_val;
                flush_reg <= 1'b1;
            end else begin
                pc_reg <= pc_reg + 13'h0001;
                if (is_btss && bit_one_reg) begin
                    flush_reg <= 1'b1;
                end
            end
        end
    end

    // Return stack: circular, push on call, pop on either return
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sp_reg    <= 3'h0;
            depth_reg <= 4'h0;
        end else if (phase_reg == bcr_pkg::BCR_Q4) begin
            if (is_call) begin
                // pc already holds the return address thanks to prefetch
                stk_reg[sp_reg] <= pc_reg;
                sp_reg          <= sp_reg + 3'h1;
                if (depth_reg != 4'(STK_D)) depth_reg <= depth_reg + 4'h1;
            end else if (is_return_with_literal || is_ret) begin
                sp_reg <= sp_reg - 3'h1;
                if (depth_reg != 4'h0) depth_reg <= depth_reg - 4'h1;
            end
        end
    end

    // W gets the literal or the incremented value; zero flag only from increment
    always_ff @(posedge core_clk) begin
        if (reset) begin
            w_reg     <= 8'h00;
            zero_flag <= 1'b0;
        end else if (phase_reg == bcr_pkg::BCR_Q4) begin
            if (is_return_with_literal) begin
                w_reg <= ir_reg[7:0];
            end else if (is_inc) begin
                if (!ir_reg[bcr_pkg::DEST_POS]) w_reg <= sum_reg;
                zero_flag <= (sum_reg == 8'h00);
            end
        end
    end

    // File port: address always from the word, write strobe in Q4 only
    assign file_addr  = ir_reg[bcr_pkg::FADDR_W-1:0];
    assign file_wdata = sum_reg;
    assign file_we    = phase_reg == bcr_pkg::BCR_Q4 && is_inc
                        && ir_reg[bcr_pkg::DEST_POS];
    assign zero_we    = phase_reg == bcr_pkg::BCR_Q4 && is_inc;
    assign pc_out     = pc_reg;
    assign w_out      = w_reg;
    assign phase_out  = phase_reg;
    assign flush_out  = flush_reg;
    assign stack_top  = pop_val;
    assign stack_top_valid = depth_reg != 4'h0;

    // Checks: results land on the Q4 edge, so consequents look one clock later; the Q4 write strobes are checked in Q4 itself
    sequence q4_s;
        phase_reg == bcr_pkg::BCR_Q4;
    endsequence

    // A voided word holds flush for one whole cycle; it must never chain into another
    sequence void_cycle_s;
        flush_reg [*4] ##1 !flush_reg;
    endsequence

    skip_flush_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_btss && bit_one_reg |=> void_cycle_s)
        else $error("skip did not void next word");

    noskip_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_btss && !bit_one_reg |=> !flush_reg ##0 pc_reg == $past(pc_reg) + 13'h0001)
        else $error("no-skip path disturbed");

    call_push_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_call |=> stk_reg[$past(sp_reg)] == $past(pc_reg))
        else $error("call pushed wrong address");

    call_tgt_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_call |=> pc_reg == $past(target))
        else $error("call target wrong");

    call_void_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_call |=> stack_top_valid ##0 void_cycle_s)
        else $error("call second cycle not voided");

    jump_tgt_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_jump |=> pc_reg == $past(target) ##0 flush_reg)
        else $error("jump target wrong");

    jump_stack_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_jump |=> $stable(sp_reg) ##0 void_cycle_s)
        else $error("jump touched the stack");

    inc_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_inc |=> zero_flag == ($past(sum_reg) == 8'h00))
        else $error("increment zero flag wrong");

    inc_w_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_inc && !ir_reg[bcr_pkg::DEST_POS] |=> w_reg == $past(sum_reg) ##0 !flush_reg)
        else $error("increment to accumulator wrong");

    inc_file_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_inc && ir_reg[bcr_pkg::DEST_POS] |-> file_we ##1 $stable(w_reg))
        else $error("increment to file wrong");

    return_with_literal_w_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_return_with_literal |=> w_reg == $past(ir_reg[7:0]) ##0 $stable(zero_flag))
        else $error("literal return wrong");

    return_with_literal_pc_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_return_with_literal |=> pc_reg == $past(pop_val) ##0 void_cycle_s)
        else $error("literal return pop wrong");

    ret_pop_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_ret |=> pc_reg == $past(pop_val) ##0 sp_reg == $past(sp_reg) - 3'h1)
        else $error("return pop wrong");

    ret_flags_a: assert property (@(posedge core_clk) disable iff (reset)
        q4_s and is_ret |=> $stable(zero_flag) ##0 $stable(w_reg) ##0 void_cycle_s)
        else $error("return disturbed flags");

    flush_nop_a: assert property (@(posedge core_clk) disable iff (reset)
        flush_reg |-> !file_we && !zero_we)
        else $error("flushed cycle had effect");
endmodule

// >>> bcr_far_mem.sv
// Partner model: program memory and data file registers around the decoder
`timescale 1ns/1ps
module bcr_far_mem (
    input  wire logic                        core_clk,
    input  wire logic [bcr_pkg::PC_W-1:0]    pc_out,
    output logic [bcr_pkg::INSN_W-1:0]       insn_data,
    input  wire logic [bcr_pkg::FADDR_W-1:0] file_addr,
    output logic [7:0]                       file_rdata,
    input  wire logic [7:0]                  file_wdata,
    input  wire logic                        file_we
);
    logic [bcr_pkg::INSN_W-1:0] rom [64];
    logic [7:0]                 regs [128];
    // Words alias every 64 addresses; keeps the model small, so targets stay distinct
    assign insn_data  = rom[pc_out[5:0]];
    assign file_rdata = regs[file_addr];
    // A write lands on the edge where the decoder strobes it
    always @(posedge core_clk) begin
        if (file_we) begin
            regs[file_addr] <= file_wdata;
        end
    end
    // Program: increments, both skip outcomes, call, return_with_literal, jump, call, return
    initial begin
        foreach (rom[i]) rom[i] = 14'h0000;
        foreach (regs[i]) regs[i] = 8'h00;
        regs[5] = 8'hFF;
        regs[6] = 8'h80;
        rom[0]  = 14'h0A85; // Increment into the file, wraps to zero
        rom[1]  = 14'h0A05; // Increment into the accumulator
        rom[2]  = 14'h1C05; // Tested bit clear, no skip
        rom[3]  = 14'h1F86; // Tested bit set, skip
        rom[4]  = 14'h0A85; // Skipped: must not write
        rom[5]  = 14'h2014;
        rom[6]  = 14'h2820;
        rom[20] = 14'h37AB; // Don't-care bits set on purpose
        rom[32] = 14'h2030;
        rom[33] = 14'h2821;
        rom[48] = 14'h0008;
    end
endmodule

// >>> tb_branch_call_return_decode.sv
// Testbench: runs a short program through the decoder and checks state each cycle
`timescale 1ns/1ps
module tb_branch_call_return_decode;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  upper_pc_latch = 8'hE8;
    logic [13:0] insn_data;
    logic [7:0]  file_rdata;
    logic [7:0]  file_wdata;
    logic [7:0]  w_out;
    logic [6:0]  file_addr;
    logic [12:0] pc_out;
    logic [12:0] stack_top;
    logic        file_we;
    logic        zero_flag;
    logic        zero_we;
    logic        flush_out;
    logic        stack_top_valid;
    logic [1:0]  phase_out;
    logic [23:0] seen;
    int          num_errors = 0;
    int          comparisons = 0;
    // Expected {pc, accumulator, zero, flush, stack valid} after each cycle's Q4 edge
    logic [23:0] rows [17] = '{
        {13'h001, 8'h00, 3'h0}, {13'h002, 8'h00, 3'h4}, {13'h003, 8'h01, 3'h0},
        {13'h004, 8'h01, 3'h0}, {13'h005, 8'h01, 3'h2}, {13'h006, 8'h01, 3'h0},
        {13'h814, 8'h01, 3'h3}, {13'h815, 8'h01, 3'h1}, {13'h006, 8'hAB, 3'h2},
        {13'h007, 8'hAB, 3'h0}, {13'h820, 8'hAB, 3'h2}, {13'h821, 8'hAB, 3'h0},
        {13'h830, 8'hAB, 3'h3}, {13'h831, 8'hAB, 3'h1}, {13'h821, 8'hAB, 3'h2},
        {13'h822, 8'hAB, 3'h0}, {13'h821, 8'hAB, 3'h2}};

    bcr_decoder uut (.core_clk, .reset, .insn_data, .file_rdata, .upper_pc_latch,
        .pc_out, .file_addr, .file_wdata, .file_we, .w_out, .zero_flag, .zero_we,
        .phase_out, .flush_out, .stack_top_valid, .stack_top);
    bcr_far_mem far_mem (.core_clk, .pc_out, .insn_data, .file_addr, .file_rdata,
        .file_wdata, .file_we);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // 50 MHz core clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Watchdog: the program needs about 100 cycles, so 2500 means a hang
    initial begin
        #50000;
        num_errors++;
        tally_and_finish();
    end

    // Latch holds other bits set, so only bits 4:3 may reach the counter
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            // Strobes are combinational in Q4, so look before the edge that ends it
            @(negedge core_clk iff phase_out == 2'h3);
            check({file_we, zero_we}, (i == 1) ? 2'h3 : (i == 2) ? 2'h1 : 2'h0);
            if (i == 1) check({file_addr, file_wdata}, {7'h05, 8'h00});
            if (i == 5) check(file_we, 1'b0);
            @(posedge core_clk);
            #1;
            seen = {pc_out, w_out, zero_flag, flush_out, stack_top_valid};
            check(seen[23:11], rows[i][23:11]);
            check(seen[10:0], rows[i][10:0]);
            if (i == 6 || i == 7) check(stack_top, 13'h006);
            if (i == 12 || i == 13) check(stack_top, 13'h821);
        end
        check(far_mem.regs[5], 8'h00); // Skipped increment left the file alone
        // Reset in mid-run clears counter, phase, accumulator, flush and stack
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        #1;
        check({pc_out, w_out, phase_out, flush_out, stack_top_valid, zero_flag}, 27'h0);
        // Second release: the first fetch of address zero lands on the fourth edge
        @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check({pc_out, phase_out, flush_out}, {13'h001, 2'h0, 1'b0});
        tally_and_finish();
    end
endmodule
